/* hdl/ext_irq_pkg.sv */
// Package: register map, field layout and sense codes of the interrupt block
package ext_irq_pkg;
  localparam int unsigned NUM_LINES = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_CLEAR_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_SET_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_FLAG_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] WAKE_ENABLE_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] SENSE_LO_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] SENSE_HI_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h20;
  localparam int unsigned LINE_LSB = 0;
  localparam int unsigned SENSE_W = 3;
  localparam int unsigned SENSE_STRIDE = 4;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] WAKE_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  localparam logic [31:0] SENSE_RESET = 32'h0000_0000;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SENSE_NONE = 3'h0,
    SENSE_RISE = 3'h1,
    SENSE_FALL = 3'h2,
    SENSE_BOTH = 3'h3,
    SENSE_HIGH = 3'h4,
    SENSE_LOW = 3'h5
  } sense_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage : ext_irq_pkg

/* hdl/ext_irq_sync.sv */
// Two-stage synchroniser for the external interrupt pins
`timescale 1ns/10ps
module ext_irq_sync import ext_irq_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [NUM_LINES-1:0] i_async,
  output logic [NUM_LINES-1:0] o_sync
);
  logic [NUM_LINES-1:0] meta_reg;
  logic [NUM_LINES-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : ext_irq_sync

/* hdl/ext_irq_sense.sv */
// Per-line sense match: edge and level detection from a sense code
`timescale 1ns/10ps
module ext_irq_sense import ext_irq_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [NUM_LINES-1:0] i_pin,
  input wire logic [NUM_LINES*SENSE_STRIDE-1:0] i_cfg,
  output logic [NUM_LINES-1:0] o_match
);
  logic [NUM_LINES-1:0] prev_reg;
  logic [NUM_LINES-1:0] prev_next;

  function automatic logic sense_hit(input logic [2:0] code,
                                     input logic now, input logic was);
    unique case (code)
      SENSE_RISE: sense_hit = now & ~was;
      SENSE_FALL: sense_hit = ~now & was;
      SENSE_BOTH: sense_hit = now ^ was;
      SENSE_HIGH: sense_hit = now;
      SENSE_LOW: sense_hit = ~now;
      // None and the reserved codes never match
      default: sense_hit = 1'b0;
    endcase
  endfunction : sense_hit

  always_comb begin
    prev_next = i_pin;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    assign o_match[g] = sense_hit(i_cfg[g*SENSE_STRIDE +: SENSE_W],
                                  i_pin[g], prev_reg[g]);
  end
endmodule : ext_irq_sense

/* hdl/ext_irq_enable_flag_wake.sv */
// Top: enable, flag and wake-up control of sixteen external interrupt lines
//
// Functional notes
// - Sixteen lines, bits 15..0 in each register, bits 31..16 read zero; the sense registers at 0x18 and 0x1C read all 32 bits.
// - Writing one to enable-set at 0x0C enables that line only.
// - Writing zero to enable-set leaves the enable unchanged.
// - Enable-set reads back one per enabled line.
// - A pin sense match sets the line's flag at 0x10.
// - Interrupt request while any line has flag and enable both set; the code also requires that line's mask bit.
// - Writing one to a flag bit clears it; only software clear.
// - Writing zero to a flag bit leaves it unchanged.
// - A match on a wake-enabled line wakes the device; otherwise not.
// - Sense codes: none, rise, fall, both, high, low; 6-7 reserved.
// - Writing one to enable-clear at 0x08 disables; reads enable state.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module ext_irq_enable_flag_wake import ext_irq_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_LINES-1:0] i_ext_irq_line,
  output logic o_irq,
  output logic o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin path

  logic [NUM_LINES-1:0] pin_sync;
  logic [NUM_LINES-1:0] match;
  logic [31:0] sense_lo_reg;
  logic [31:0] sense_hi_reg;

  ext_irq_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_async(i_ext_irq_line),
    .o_sync(pin_sync)
  );

  ext_irq_sense u_sense (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_pin(pin_sync),
    .i_cfg({sense_hi_reg, sense_lo_reg}),
    .o_match(match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and register file

  apb_req_t req;
  logic [NUM_LINES-1:0] enable_reg, enable_next;
  logic [NUM_LINES-1:0] flag_reg, flag_next;
  logic [NUM_LINES-1:0] wake_en_reg, wake_en_next;
  logic [NUM_LINES-1:0] mask_reg, mask_next;
  logic [31:0] sense_lo_next, sense_hi_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic setup, wr_acc;
  logic [NUM_LINES-1:0] wr_line;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == IRQ_ENABLE_CLEAR_OFS) || (a == IRQ_ENABLE_SET_OFS) ||
                 (a == IRQ_FLAG_OFS) || (a == WAKE_ENABLE_OFS) ||
                 (a == SENSE_LO_OFS) || (a == SENSE_HI_OFS) ||
                 (a == IRQ_MASK_OFS);
  endfunction : addr_known

  function automatic logic is_wr(input apb_req_t r,
                                 input logic [ADDR_W-1:0] ofs);
    is_wr = r.psel & r.penable & r.pwrite & (r.paddr == ofs);
  endfunction : is_wr

  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                 paddr: i_paddr, pwdata: i_pwdata};
  // Setup phase registers the answer, so ready stands in the first access cycle with no wait state
  assign setup = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite & pready_reg;
  assign wr_line = i_pwdata[LINE_LSB +: NUM_LINES];

  always_comb begin
    enable_next = enable_reg;
    flag_next = flag_reg;
    wake_en_next = wake_en_reg;
    mask_next = mask_reg;
    sense_lo_next = sense_lo_reg;
    sense_hi_next = sense_hi_reg;
    if (wr_acc && is_wr(req, IRQ_ENABLE_SET_OFS)) begin
      enable_next = enable_reg | wr_line;
    end
    if (wr_acc && is_wr(req, IRQ_ENABLE_CLEAR_OFS)) begin
      enable_next = enable_reg & ~wr_line;
    end
    if (wr_acc && is_wr(req, IRQ_FLAG_OFS)) begin
      flag_next = flag_reg & ~wr_line;
    end
    // Set after clear so a coincident detection survives
    flag_next = flag_next | match;
    if (wr_acc && is_wr(req, WAKE_ENABLE_OFS)) begin
      wake_en_next = wr_line;
    end
    if (wr_acc && is_wr(req, IRQ_MASK_OFS)) begin
      mask_next = wr_line;
    end
    if (wr_acc && is_wr(req, SENSE_LO_OFS)) begin
      sense_lo_next = i_pwdata;
    end
    if (wr_acc && is_wr(req, SENSE_HI_OFS)) begin
      sense_hi_next = i_pwdata;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next = 1'b1;
      pslverr_next = ~addr_known(i_paddr);
      prdata_next = 32'h0000_0000;
      unique case (i_paddr)
        IRQ_ENABLE_CLEAR_OFS, IRQ_ENABLE_SET_OFS: begin
          prdata_next[LINE_LSB +: NUM_LINES] = enable_reg;
        end
        IRQ_FLAG_OFS: prdata_next[LINE_LSB +: NUM_LINES] = flag_reg;
        WAKE_ENABLE_OFS: prdata_next[LINE_LSB +: NUM_LINES] = wake_en_reg;
        IRQ_MASK_OFS: prdata_next[LINE_LSB +: NUM_LINES] = mask_reg;
        SENSE_LO_OFS: prdata_next = sense_lo_reg;
        SENSE_HI_OFS: prdata_next = sense_hi_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and wake outputs

  always_comb begin
    // Mask gates the request; it resets open so enable alone decides
    irq_next = |(flag_reg & enable_reg & mask_reg);
    wake_next = |(match & wake_en_reg);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      enable_reg <= ENABLE_RESET;
      flag_reg <= FLAG_RESET;
      wake_en_reg <= WAKE_RESET;
      mask_reg <= MASK_RESET;
      sense_lo_reg <= SENSE_RESET;
      sense_hi_reg <= SENSE_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      flag_reg <= flag_next;
      wake_en_reg <= wake_en_next;
      mask_reg <= mask_next;
      sense_lo_reg <= sense_lo_next;
      sense_hi_reg <= sense_hi_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_irq = irq_reg;
  assign o_wake = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // One committed write access to a register
  sequence s_reg_wr(logic [ADDR_W-1:0] ofs);
    wr_acc && i_paddr == ofs;
  endsequence

  // Read setup, then the access cycle in which the answer stands
  sequence s_reg_rd(logic [ADDR_W-1:0] ofs);
    setup && !i_pwrite && i_paddr == ofs ##1 o_pready;
  endsequence

  sequence s_flag_wr(logic [NUM_LINES-1:0] bits);
    wr_acc && i_paddr == IRQ_FLAG_OFS && wr_line == bits;
  endsequence

  // Bus timing: no wait state, answer only after a setup
  chk_pready_timing: assert property (
    o_pready == $past(setup))
    else $error("ready not one cycle after setup");

  chk_slverr_unmapped: assert property (
    setup && !addr_known(i_paddr) |=>
      o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_enable_set_or: assert property (
    s_reg_wr(IRQ_ENABLE_SET_OFS) |=>
      enable_reg == ($past(enable_reg) | $past(wr_line)))
    else $error("enable set did not OR in written ones");

  chk_enable_set_keep: assert property (
    s_reg_wr(IRQ_ENABLE_SET_OFS) |=>
      ((enable_reg ^ $past(enable_reg)) & ~$past(wr_line)) == '0)
    else $error("enable set changed a line written with zero");

  chk_enable_clear: assert property (
    s_reg_wr(IRQ_ENABLE_CLEAR_OFS) |=>
      enable_reg == ($past(enable_reg) & ~$past(wr_line)))
    else $error("enable clear did not clear written ones");

  chk_enable_read: assert property (
    s_reg_rd(IRQ_ENABLE_SET_OFS) |->
      o_prdata == {16'h0000, $past(enable_reg)})
    else $error("enable read value wrong");

  chk_clear_read: assert property (
    s_reg_rd(IRQ_ENABLE_CLEAR_OFS) |->
      o_prdata == {16'h0000, $past(enable_reg)})
    else $error("enable clear read value wrong");

  // Flags: set by a match, dropped only by a one written to them
  chk_flag_read: assert property (
    s_reg_rd(IRQ_FLAG_OFS) |->
      o_prdata == {16'h0000, $past(flag_reg)})
    else $error("flag read value wrong");

  chk_flag_set: assert property (
    |match |=>
      (flag_reg & $past(match)) == $past(match))
    else $error("match did not set flag");

  chk_flag_sticky: assert property (
    !(wr_acc && i_paddr == IRQ_FLAG_OFS) |=>
      (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("flag dropped without software clear");

  chk_flag_w1c: assert property (
    s_flag_wr(16'h0001) and (!match[0] && flag_reg[0]) |=>
      !flag_reg[0])
    else $error("flag not cleared by one");

  chk_flag_w0: assert property (
    s_reg_wr(IRQ_FLAG_OFS) |=> ((flag_reg ^ $past(flag_reg)) &
      ~$past(wr_line) & ~$past(match)) == '0)
    else $error("flag changed by zero write");

  chk_set_wins: assert property (
    s_reg_wr(IRQ_FLAG_OFS) and (|match) |=>
      (flag_reg & $past(match)) == $past(match))
    else $error("clear beat coincident set");

  // Request and wake follow their sources one cycle later
  chk_irq_level: assert property (
    o_irq ==
      $past(|(flag_reg & enable_reg & mask_reg)))
    else $error("irq level does not follow flag and enable");

  chk_mask_write: assert property (
    s_reg_wr(IRQ_MASK_OFS) |=>
      mask_reg == $past(wr_line))
    else $error("mask write not taken");

  chk_wake_write: assert property (
    s_reg_wr(WAKE_ENABLE_OFS) |=>
      wake_en_reg == $past(wr_line))
    else $error("wake enable write not taken");

  chk_wake_gate: assert property (
    o_wake ==
      $past(|(match & wake_en_reg)))
    else $error("wake does not follow enabled match");

  chk_sense_lo_write: assert property (
    s_reg_wr(SENSE_LO_OFS) |=>
      sense_lo_reg == $past(i_pwdata))
    else $error("low sense write not taken");

  chk_sense_hi_write: assert property (
    s_reg_wr(SENSE_HI_OFS) |=>
      sense_hi_reg == $past(i_pwdata))
    else $error("high sense write not taken");

  chk_upper_zero: assert property (
    o_pready |-> o_prdata[31:16] == 16'h0000 ||
      $past(i_paddr) == SENSE_LO_OFS || $past(i_paddr) == SENSE_HI_OFS)
    else $error("upper bits not zero");

endmodule : ext_irq_enable_flag_wake

/* tb/ext_irq_far_end.sv */
// Far-side model: external pin driver and wake pulse counter
`timescale 1ns/10ps
module ext_irq_far_end import ext_irq_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [NUM_LINES-1:0] i_pin_req,
  input wire logic i_wake,
  output logic [NUM_LINES-1:0] o_pin,
  output logic [7:0] o_wake_cnt
);
  // Pins move only on the clock edge, like a registered pad driver
  always_ff @(posedge i_clk_sys) begin
    o_pin <= i_pin_req;
    if (i_srst) begin
      o_wake_cnt <= 8'h00;
    end else begin
      o_wake_cnt <= o_wake_cnt + {7'h00, i_wake};
    end
  end
endmodule : ext_irq_far_end

/* tb/ext_irq_enable_flag_wake_tb.sv */
// Bench: register, flag, interrupt and wake checks of the line controller
`timescale 1ns/10ps
module ext_irq_enable_flag_wake_tb import ext_irq_pkg::*; ;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] q;
  logic e;
  logic [15:0] pin_req = 16'h0000;
  logic [15:0] pins;
  logic [31:0] rdata;
  logic rdy, err, irq, wake;
  logic [7:0] wcnt;
  int n_mismatch = 0;
  int n_tests = 0;

  always #2.5 clk = ~clk;

  ext_irq_enable_flag_wake ext_irq_enable_flag_wake_i (.i_clk_sys(clk),
    .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(rdata), .o_pready(rdy),
    .o_pslverr(err), .i_ext_irq_line(pins), .o_irq(irq), .o_wake(wake));

  ext_irq_far_end ext_irq_far_end_i (.i_clk_sys(clk), .i_srst(srst),
    .i_pin_req(pin_req), .i_wake(wake), .o_pin(pins), .o_wake_cnt(wcnt));

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, rdy, 1'b1);
    end
    q = rdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Level senses count too: each matches either after the pin change or in the clear write cycle before it arrives, and the flag holds
  function automatic logic f_rise(input logic [2:0] c);
    return c inside {3'h1, 3'h3, 3'h4, 3'h5};
  endfunction : f_rise

  function automatic logic f_fall(input logic [2:0] c);
    return c inside {3'h2, 3'h3, 3'h4, 3'h5};
  endfunction : f_fall

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    logic [31:0] en, v;
    logic [15:0] m;
    logic [7:0] c0;
    v = $urandom(19935);
    wt(10);
    srst <= 1'b0;
    wt(1);
    rd(IRQ_ENABLE_SET_OFS);
    chk(q, 32'h0);
    rd(IRQ_FLAG_OFS);
    chk(q, 32'h0);
    rd(WAKE_ENABLE_OFS);
    chk(q, 32'h0);
    rd(IRQ_MASK_OFS);
    chk(q, 32'h0000_FFFF);
    $display("test reset values done");
    en = 32'h0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      wr(IRQ_ENABLE_SET_OFS, v);
      en = en | (v & 32'h0000_FFFF);
      rd(IRQ_ENABLE_SET_OFS);
      chk(q, en);
      v = $urandom() & $urandom();
      wr(IRQ_ENABLE_CLEAR_OFS, v);
      en = en & ~v;
      rd(IRQ_ENABLE_CLEAR_OFS);
      chk(q, en);
    end
    wr(IRQ_ENABLE_SET_OFS, 32'h0);
    rd(IRQ_ENABLE_SET_OFS);
    chk(q, en);
    // Line 1 forced on so the request checks below cannot pass idly
    wr(IRQ_ENABLE_SET_OFS, 32'h0000_0002);
    en = en | 32'h0000_0002;
    $display("test enable set and clear done");
    wr(SENSE_LO_OFS, 32'h1111_1111);
    wr(SENSE_HI_OFS, 32'h1111_1111);
    rd(SENSE_HI_OFS);
    chk(q, 32'h1111_1111);
    m = 16'($urandom()) | 16'h0002;
    pin_req <= m;
    wt(8);
    rd(IRQ_FLAG_OFS);
    chk(q, {16'h0, m});
    chk({31'h0, irq}, {31'h0, |(m & en[15:0])});
    wr(IRQ_MASK_OFS, 32'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFS, 32'h0000_FFFF);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    v = $urandom() & 32'hFFFF;
    wr(IRQ_FLAG_OFS, v);
    rd(IRQ_FLAG_OFS);
    chk(q, {16'h0, m & ~v[15:0]});
    wr(IRQ_FLAG_OFS, 32'hFFFF_FFFF);
    wt(3);
    chk({31'h0, irq}, 32'h0);
    pin_req <= 16'h0000;
    wt(8);
    rd(IRQ_FLAG_OFS);
    chk(q, 32'h0);
    $display("test flags and request done");
    wr(WAKE_ENABLE_OFS, 32'hFFFF_0001);
    rd(WAKE_ENABLE_OFS);
    chk(q, 32'h1);
    c0 = wcnt;
    pin_req <= 16'h0002;
    wt(8);
    chk({24'h0, wcnt}, {24'h0, c0});
    pin_req <= 16'h0003;
    wt(8);
    chk({24'h0, wcnt}, {24'h0, c0 + 8'h01});
    pin_req <= 16'h0000;
    wt(8);
    $display("test wake done");
    for (int c = 0; c < 8; c++) begin
      wr(SENSE_LO_OFS, 32'(c));
      wt(4);
      wr(IRQ_FLAG_OFS, 32'hFFFF_FFFF);
      pin_req <= 16'h0001;
      wt(8);
      rd(IRQ_FLAG_OFS);
      chk(q, {31'h0, f_rise(3'(c))});
      wr(IRQ_FLAG_OFS, 32'h1);
      pin_req <= 16'h0000;
      wt(8);
      rd(IRQ_FLAG_OFS);
      chk(q, {31'h0, f_fall(3'(c))});
    end
    $display("test sense codes done");
    rd(8'h40);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test unmapped address done");
    finish_test;
  end
endmodule : ext_irq_enable_flag_wake_tb
